// ===== atpg_pkg.sv
// Package: register map, selector codes and reset values of the output test pattern generator
package atpg_pkg;
   // Register indices; each register takes one aligned APB word at byte address index*4
   localparam logic [11:0] IDX_CTRL       = 12'h550;
   localparam logic [11:0] IDX_UPAT1_LO   = 12'h551;
   localparam logic [11:0] IDX_UPAT1_HI   = 12'h552;
   localparam logic [11:0] IDX_UPAT2_LO   = 12'h553;
   localparam logic [11:0] IDX_UPAT2_HI   = 12'h554;
   localparam logic [11:0] IDX_UPAT3_LO   = 12'h555;
   localparam logic [11:0] IDX_UPAT3_HI   = 12'h556;
   localparam logic [11:0] IDX_UPAT4_LO   = 12'h557;
   localparam logic [11:0] IDX_UPAT4_HI   = 12'h558;
   localparam logic [11:0] IDX_STATUS     = 12'h559;
   localparam int          ADDR_W         = 14;

   // Control register fields
   localparam int          CTRL_ORDER_BIT = 7;
   localparam int          CTRL_LRST_BIT  = 5;
   localparam int          CTRL_SRST_BIT  = 4;
   localparam logic [7:0]  CTRL_RESET     = 8'h00;
   localparam logic [7:0]  CTRL_WMASK     = 8'hBF;
   localparam logic [7:0]  UPAT_RESET     = 8'h00;

   // Selector codes
   localparam logic [3:0]  SEL_NORMAL     = 4'h0;
   localparam logic [3:0]  SEL_MIDSCALE   = 4'h1;
   localparam logic [3:0]  SEL_POS_FS     = 4'h2;
   localparam logic [3:0]  SEL_NEG_FS     = 4'h3;
   localparam logic [3:0]  SEL_CHECKER    = 4'h4;
   localparam logic [3:0]  SEL_PN_LONG    = 4'h5;
   localparam logic [3:0]  SEL_PN_SHORT   = 4'h6;
   localparam logic [3:0]  SEL_TOGGLE     = 4'h7;
   localparam logic [3:0]  SEL_USER       = 4'h8;
   localparam logic [3:0]  SEL_RAMP       = 4'hF;

   // Generator seeds (reset values of the shift registers)
   localparam logic [22:0] PN_LONG_SEED   = 23'h7FFFFF;
   localparam logic [8:0]  PN_SHORT_SEED  = 9'h1FF;

   // User sequencer states
   typedef enum logic [2:0] {
      ATPG_SEQ_RUN  = 3'b001,
      ATPG_SEQ_DONE = 3'b010,
      ATPG_SEQ_IDLE = 3'b100
   } atpg_seq_e;
endpackage

// ===== atpg_fifo.sv
// Module: synchronous valid/ready FIFO with parameterised width and depth
module atpg_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk,      // Clock
   input  wire logic             rstn,      // Async reset, active low
   input  wire logic [WIDTH-1:0] in_data,   // Write data
   input  wire logic             in_valid,  // Write request
   output logic                  in_ready,  // Not full
   output logic      [WIDTH-1:0] out_data,  // Head word
   output logic                  out_valid, // Not empty
   input  wire logic             out_ready  // Consumer takes head
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wr_ptr_r;
   logic [AW-1:0]    rd_ptr_r;
   logic [AW:0]      count_r;
   logic [AW:0]      count_nxt;
   logic             push;
   logic             pop;

   // Flags are registered from the next count, so both sides see flop outputs
   assign count_nxt = count_r + (AW+1)'(push) - (AW+1)'(pop);
   assign out_data  = mem[rd_ptr_r];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;

   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wr_ptr_r] <= in_data;
      end
   end

   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         wr_ptr_r <= '0;
         rd_ptr_r <= '0;
         count_r  <= '0;
         in_ready  <= 1'b1;
         out_valid <= 1'b0;
      end else begin
         in_ready  <= (count_nxt != (AW+1)'(DEPTH));
         out_valid <= (count_nxt != '0);
         if (push) begin
            wr_ptr_r <= (wr_ptr_r == AW'(DEPTH-1)) ? '0 : wr_ptr_r + 1'b1;
         end
         if (pop) begin
            rd_ptr_r <= (rd_ptr_r == AW'(DEPTH-1)) ? '0 : rd_ptr_r + 1'b1;
         end
         count_r <= count_nxt;
      end
   end
endmodule // atpg_fifo

// ===== atpg_top.sv
// Module: converter output test pattern generator with APB register slave

module atpg_top #(
   parameter int DW    = 16,
   parameter int DEPTH = 16
) (
   input  wire logic          mclk,       // Sample clock, 200 MHz
   input  wire logic          rstn,       // Async reset, active low
   input  wire logic [13:0]   paddr,      // APB byte address
   input  wire logic          psel,       // APB select
   input  wire logic          penable,    // APB access phase
   input  wire logic          pwrite,     // APB direction
   input  wire logic [31:0]   pwdata,     // APB write data
   input  wire logic [3:0]    pstrb,      // APB byte strobes
   output logic      [31:0]   prdata,     // APB read data
   output logic               pready,     // APB ready
   output logic               pslverr,    // APB error, unmapped address
   input  wire logic [DW-1:0] adc_data,   // Converter sample, same clock
   input  wire logic          adc_valid,  // Converter sample valid
   output logic               adc_ready,  // Path accepts a sample
   output logic      [DW-1:0] out_data,   // Output sample to framer
   output logic               out_valid,  // Output sample valid
   input  wire logic          out_ready   // Framer takes sample
);
   logic [7:0]    ctrl_r;
   logic [7:0]    upat_r [8];
   logic [22:0]   pn_long_r;
   logic [8:0]    pn_short_r;
   logic [DW-1:0] ramp_r;
   logic          phase_r;
   logic [1:0]    uidx_r;
   atpg_pkg::atpg_seq_e seq_r;
   logic [3:0]    sel;
   logic [DW-1:0] gen_word;
   logic [DW-1:0] fifo_out_data;
   logic          fifo_out_valid;
   logic          fifo_in_ready;
   logic          step;
   logic          apb_setup;
   logic          apb_wr;
   logic          mapped;
   logic [11:0]   idx;
   logic [31:0]   rdata;

   function automatic logic [DW-1:0] upat_word(input logic [1:0] n);
      upat_word = DW'({upat_r[{n, 1'b1}], upat_r[{n, 1'b0}]});
   endfunction

   function automatic logic hit(input logic [11:0] a, input logic [11:0] b);
      hit = (a == b);
   endfunction

   assign sel       = ctrl_r[3:0];
   assign idx       = paddr[13:2];
   assign mapped    = (idx >= atpg_pkg::IDX_CTRL) && (idx <= atpg_pkg::IDX_STATUS);
   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pready && pwrite && mapped;
   // Generators advance only when a word moves, so back-pressure never skips a pattern
   assign step      = fifo_in_ready && ((sel != atpg_pkg::SEL_NORMAL) || adc_valid);

   // APB: no wait state; answer raised in the first access cycle
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= apb_setup;
         pslverr <= apb_setup && !mapped;
         prdata  <= (apb_setup && !pwrite) ? rdata : '0;
      end
   end

   always_comb begin
      rdata = '0;
      if (hit(idx, atpg_pkg::IDX_CTRL)) begin
         rdata[7:0] = ctrl_r & atpg_pkg::CTRL_WMASK;
      end else if (hit(idx, atpg_pkg::IDX_STATUS)) begin
         rdata[2:0] = seq_r;
         rdata[4:3] = uidx_r;
         rdata[5]   = fifo_out_valid;
         rdata[6]   = fifo_in_ready;
      end else if (mapped) begin
         rdata[7:0] = upat_r[3'(idx - atpg_pkg::IDX_UPAT1_LO)];
      end
   end

   // Control register; bit 6 reserved and reads zero
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ctrl_r <= atpg_pkg::CTRL_RESET;
      end else if (apb_wr && pstrb[0] && hit(idx, atpg_pkg::IDX_CTRL)) begin
         ctrl_r <= pwdata[7:0] & atpg_pkg::CTRL_WMASK;
      end
   end

   // User pattern bytes, low then high for patterns 1 to 4
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 8; i++) begin
            upat_r[i] <= atpg_pkg::UPAT_RESET;
         end
      end else if (apb_wr && pstrb[0] && !hit(idx, atpg_pkg::IDX_CTRL)
                   && !hit(idx, atpg_pkg::IDX_STATUS)) begin
         upat_r[3'(idx - atpg_pkg::IDX_UPAT1_LO)] <= pwdata[7:0];
      end
   end

   // Long pseudorandom: x^23 + x^18 + 1
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pn_long_r <= atpg_pkg::PN_LONG_SEED;
      end else if (ctrl_r[atpg_pkg::CTRL_LRST_BIT]) begin
         pn_long_r <= atpg_pkg::PN_LONG_SEED;
      end else if (step && sel == atpg_pkg::SEL_PN_LONG) begin
         pn_long_r <= {pn_long_r[21:0], pn_long_r[22] ^ pn_long_r[17]};
      end
   end

   // Short pseudorandom: x^9 + x^5 + 1
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         pn_short_r <= atpg_pkg::PN_SHORT_SEED;
      end else if (ctrl_r[atpg_pkg::CTRL_SRST_BIT]) begin
         pn_short_r <= atpg_pkg::PN_SHORT_SEED;
      end else if (step && sel == atpg_pkg::SEL_PN_SHORT) begin
         pn_short_r <= {pn_short_r[7:0], pn_short_r[8] ^ pn_short_r[4]};
      end
   end

   // Ramp and alternating phase for checkerboard and word toggle
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         ramp_r  <= '0;
         phase_r <= 1'b0;
      end else if (step) begin
         ramp_r  <= (sel == atpg_pkg::SEL_RAMP) ? ramp_r + 1'b1 : ramp_r;
         phase_r <= !phase_r;
      end
   end

   // User sequencer; leaving user mode rearms it at pattern 1
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         seq_r  <= atpg_pkg::ATPG_SEQ_IDLE;
         uidx_r <= '0;
      end else if (sel != atpg_pkg::SEL_USER) begin
         seq_r  <= atpg_pkg::ATPG_SEQ_IDLE;
         uidx_r <= '0;
      end else if (step) begin
         case (seq_r)
            atpg_pkg::ATPG_SEQ_IDLE: begin
               seq_r  <= atpg_pkg::ATPG_SEQ_RUN;
               uidx_r <= 2'h1;
            end
            atpg_pkg::ATPG_SEQ_RUN: begin
               uidx_r <= uidx_r + 1'b1;
               if (uidx_r == 2'h3 && ctrl_r[atpg_pkg::CTRL_ORDER_BIT]) begin
                  seq_r <= atpg_pkg::ATPG_SEQ_DONE;
               end
            end
            atpg_pkg::ATPG_SEQ_DONE: begin
               seq_r <= atpg_pkg::ATPG_SEQ_DONE;
            end
            default: begin
               seq_r  <= atpg_pkg::ATPG_SEQ_IDLE;
               uidx_r <= '0;
            end
         endcase
      end
   end

   // Word selection, two's complement output
   always_comb begin
      gen_word = '0;
      case (sel)
         atpg_pkg::SEL_NORMAL:   gen_word = adc_data;
         atpg_pkg::SEL_MIDSCALE: gen_word = '0;
         atpg_pkg::SEL_POS_FS:   gen_word = {1'b0, {(DW-1){1'b1}}};
         atpg_pkg::SEL_NEG_FS:   gen_word = {1'b1, {(DW-1){1'b0}}};
         atpg_pkg::SEL_CHECKER:  gen_word = phase_r ? {(DW/2){2'b10}} : {(DW/2){2'b01}};
         atpg_pkg::SEL_PN_LONG:  gen_word = DW'(pn_long_r);
         atpg_pkg::SEL_PN_SHORT: gen_word = DW'(pn_short_r);
         atpg_pkg::SEL_TOGGLE:   gen_word = phase_r ? '1 : '0;
         atpg_pkg::SEL_RAMP:     gen_word = ramp_r;
         atpg_pkg::SEL_USER: begin
            if (seq_r == atpg_pkg::ATPG_SEQ_DONE) begin
               gen_word = '0;
            end else if (seq_r == atpg_pkg::ATPG_SEQ_IDLE) begin
               gen_word = upat_word(2'h0);
            end else begin
               gen_word = upat_word(uidx_r);
            end
         end
         default:                gen_word = '0;
      endcase
   end

   assign adc_ready = fifo_in_ready;

   atpg_fifo #(
      .WIDTH (DW),
      .DEPTH (DEPTH)
   ) u_fifo (
      .mclk      (mclk),
      .rstn      (rstn),
      .in_data   (gen_word),
      .in_valid  (step),
      .in_ready  (fifo_in_ready),
      .out_data  (fifo_out_data),
      .out_valid (fifo_out_valid),
      .out_ready (!out_valid || out_ready)
   );

   // Output stage register; refills only when empty or being taken
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         out_data  <= '0;
         out_valid <= 1'b0;
      end else if (!out_valid || out_ready) begin
         out_data  <= fifo_out_data;
         out_valid <= fifo_out_valid;
      end
   end
endmodule // atpg_top

// ===== atpg_top_checker.sv
// Checker: APB answer and output-stream assertions for the pattern generator
module atpg_top_checker #(
   parameter int DW    = 16,
   parameter int DEPTH = 16
) (
   input wire logic          mclk,      // Clock
   input wire logic          rstn,      // Reset, active low
   input wire logic [13:0]   paddr,     // APB address
   input wire logic          psel,      // APB select
   input wire logic          penable,   // APB access
   input wire logic          pwrite,    // APB direction
   input wire logic [31:0]   prdata,    // APB read data
   input wire logic          pready,    // APB ready
   input wire logic          pslverr,   // APB error
   input wire logic [DW-1:0] out_data,  // Output word
   input wire logic          out_valid, // Output valid
   input wire logic          out_ready  // Output taken
);
   timeunit 1ns;
   timeprecision 1ps;
   logic mapped;
   assign mapped = paddr[13:2] >= atpg_pkg::IDX_CTRL && paddr[13:2] <= atpg_pkg::IDX_STATUS;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence s_setup;
      psel && !penable;
   endsequence
   sequence s_access;
      psel && penable && pready;
   endsequence
   a_ready_after_setup: assert property (s_setup |=> s_access)
      else $error("no answer in the cycle after setup");
   a_ready_one_cycle: assert property (pready |=> !pready)
      else $error("ready held longer than one cycle");
   a_ready_in_access: assert property (pready |-> psel && penable)
      else $error("ready outside an access phase");
   a_err_unmapped: assert property (psel && !penable && !mapped |=> pslverr)
      else $error("unmapped access not refused");
   a_ok_mapped: assert property (psel && !penable && mapped |=> !pslverr)
      else $error("mapped access refused");
   a_rdata_quiet: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside the answer cycle");
   a_err_reads_zero: assert property (pslverr && !pwrite |-> prdata == 32'h0)
      else $error("refused read returned data");
   a_out_holds_stall: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
      else $error("output word changed while stalled");
endmodule // atpg_top_checker

bind atpg_top atpg_top_checker #(.DW(DW), .DEPTH(DEPTH)) atpg_top_checker_i (.mclk(mclk),
   .rstn(rstn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .out_data(out_data),
   .out_valid(out_valid), .out_ready(out_ready));

// ===== atpg_sink.sv
// Partner model: downstream framer that takes output words and can stall
module atpg_sink (
   input  wire logic mclk,     // Clock
   input  wire logic rstn,     // Reset, active low
   input  wire logic hold,     // Bench requests a stall
   output logic      out_ready // Word taken
);
   timeunit 1ns;
   timeprecision 1ps;
   // Ready is registered, so a stall lands one cycle late as in a real framer
   always_ff @(posedge mclk or negedge rstn) begin
      if (!rstn) begin
         out_ready <= 1'h0;
      end else begin
         out_ready <= !hold;
      end
   end
endmodule // atpg_sink

// ===== atpg_tb.sv
// Testbench: register access, pattern modes and output stall checks
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk, pready, pslverr, adc_ready, out_valid, out_ready, er, ok;
   logic        rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
   logic        adc_valid = 1'h0, hold = 1'h0;
   logic [13:0] paddr = 14'h0;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [15:0] adc_data = 16'h0, out_data, e;
   logic [15:0] q [$];
   logic [15:0] pat [4] = '{16'h1234, 16'h5678, 16'h9ABC, 16'hDEF0};
   logic [15:0] cst [3] = '{16'h0000, 16'h7FFF, 16'h8000};
   logic [7:0]  pctl [5] = '{8'h35, 8'h05, 8'h16, 8'h06, 8'h26};
   logic        held [5] = '{1'h1, 1'h0, 1'h1, 1'h0, 1'h0};
   int          failures = 0, check_count = 0, n, acc;

   atpg_top atpg_top_i (.mclk(mclk), .rstn(rstn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .adc_data(adc_data), .adc_valid(adc_valid),
      .adc_ready(adc_ready), .out_data(out_data), .out_valid(out_valid), .out_ready(out_ready));
   atpg_sink atpg_sink_i (.mclk(mclk), .rstn(rstn), .hold(hold), .out_ready(out_ready));

   initial begin
      mclk = 1'h0;
      forever #2.5 mclk = ~mclk;
   end

   // Collect at the falling edge, where the handshake is settled
   always @(negedge mclk) begin
      if (out_valid === 1'h1 && out_ready === 1'h1)
         q.push_back(out_data);
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      check_count++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t value %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      chk({31'h0, got}, {31'h0, exp});
   endtask

   // Upper data bits are junk on purpose: only the low byte may land
   task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] wd);
      int k;
      @(posedge mclk);
      psel   <= 1'h1;
      pwrite <= w;
      paddr  <= {idx, 2'h0};
      pwdata <= {24'hC3C3C3, wd};
      @(posedge mclk);
      penable <= 1'h1;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (pready !== 1'h1 && k < 20);
      if (k >= 20) begin
         failures++;
         $display("[FAIL] %0t no APB answer at index %h", $time, idx);
      end
      rd = prdata;
      er = pslverr;
      psel    <= 1'h0;
      penable <= 1'h0;
   endtask

   task automatic push(input logic [15:0] v);
      int k;
      @(posedge mclk);
      adc_valid <= 1'h1;
      adc_data  <= v;
      k = 0;
      do begin
         @(posedge mclk);
         k++;
      end while (adc_ready !== 1'h1 && k < 8);
      ok = (adc_ready === 1'h1);
      adc_valid <= 1'h0;
   endtask

   // Old words are flushed before a fresh window is captured
   task automatic mode(input logic [7:0] c);
      apb(1'h1, atpg_pkg::IDX_CTRL, c);
      repeat (40) @(posedge mclk);
      q.delete();
      repeat (12) @(posedge mclk);
      chk_bit(q.size() >= 8, 1'h1);
      n = 0;
      for (int i = 1; i < 8; i++)
         if (q[i] !== q[0])
            n++;
   endtask

   task automatic conclude;
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   initial begin
      repeat (2) @(posedge mclk);
      rstn <= 1'h1;
      for (int i = 0; i < 5; i++) begin
         apb(1'h0, atpg_pkg::IDX_CTRL + 12'(i), 8'h00);
         chk(rd, 32'h0);
      end
      apb(1'h0, 12'h600, 8'h00);
      chk_bit(er, 1'h1);
      for (int i = 0; i < 8; i++)
         apb(1'h1, atpg_pkg::IDX_UPAT1_LO + 12'(i), pat[i/2][8*(i%2) +: 8]);
      for (int i = 0; i < 8; i++) begin
         apb(1'h0, atpg_pkg::IDX_UPAT1_LO + 12'(i), 8'h00);
         chk(rd, {24'h0, pat[i/2][8*(i%2) +: 8]});
      end
      for (int i = 0; i < 3; i++) begin
         mode(8'(i + 1));
         for (int j = 0; j < 8; j++)
            chk({16'h0, q[j]}, {16'h0, cst[i]});
      end
      for (int i = 0; i < 2; i++) begin
         mode(i == 0 ? 8'h04 : 8'h07);
         e = (i == 0) ? 16'h5555 : 16'h0000;
         chk_bit(q[0] === e || q[0] === ~e, 1'h1);
         for (int j = 0; j < 7; j++)
            chk({16'h0, q[j] ^ q[j+1]}, 32'h0000FFFF);
      end
      mode(8'h0F);
      for (int j = 0; j < 7; j++)
         chk({16'h0, q[j+1]}, {16'h0, q[j] + 16'h1});
      for (int i = 0; i < 5; i++) begin
         mode(pctl[i]);
         chk_bit(n == 0, held[i]);
      end
      for (int i = 0; i < 2; i++) begin
         apb(1'h1, atpg_pkg::IDX_CTRL, 8'h00);
         repeat (40) @(posedge mclk);
         q.delete();
         hold <= (i == 1);
         apb(1'h1, atpg_pkg::IDX_CTRL, i == 0 ? 8'h88 : 8'h08);
         repeat (30) @(posedge mclk);
         hold <= 1'h0;
         repeat (40) @(posedge mclk);
         chk_bit(q.size() >= 12, 1'h1);
         for (int j = 0; j < 12; j++) begin
            e = (i == 0 && j > 3) ? 16'h0000 : pat[j%4];
            chk({16'h0, q[j]}, {16'h0, e});
         end
      end
      apb(1'h1, atpg_pkg::IDX_CTRL, 8'h00);
      repeat (40) @(posedge mclk);
      q.delete();
      hold <= 1'h1;
      acc = 0;
      ok = 1'h1;
      for (int i = 0; i < 24 && ok; i++) begin
         push(16'h3C00 + 16'(i));
         if (ok)
            acc++;
      end
      chk_bit(ok, 1'h0);
      hold <= 1'h0;
      repeat (60) @(posedge mclk);
      chk(32'(q.size()), 32'(acc));
      for (int i = 0; i < acc; i++)
         chk({16'h0, q[i]}, {16'h0, 16'h3C00 + 16'(i)});
      conclude;
   end

   initial begin
      repeat (10000) @(posedge mclk);
      failures++;
      conclude;
   end
endmodule // tb
